//--- rtl/phy_pkg.sv
// Shared constants for the transceiver status and test logic.
// Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
package phy_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int SRST_TIME_MS = 500;
  // Longest time rounds down
  localparam int SRST_CYCLES = SRST_TIME_MS * CLK_MHZ * 1000;
  localparam int LINK_WAIT_TIME_US = 330;
  // Least time rounds up (exact at this rate)
  localparam int LINK_WAIT_CYCLES = (LINK_WAIT_TIME_US * CLK_MHZ * 1000 + 999) / 1000;
  localparam int SRST_CNT_W = 26;
  localparam int LINK_CNT_W = 16;

  // ************************************************************
  // Register indices; byte address is four times the index
  // ************************************************************
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_STAT = 8'h01;
  localparam logic [7:0] IDX_EVENT = 8'h10;
  localparam logic [7:0] IDX_MODE = 8'h14;
  localparam int ADDR_W = 8;

  // ************************************************************
  // Basic control fields
  // ************************************************************
  localparam int CTRL_SRST = 15;
  localparam int CTRL_LOOP = 14;
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_ANEN = 12;
  localparam int CTRL_DUPLEX = 8;
  localparam int CTRL_COLTEST = 7;
  localparam logic [15:0] CTRL_WMASK = 16'h7180;
  localparam logic [15:0] CTRL_RESET = 16'h3000;
  // Status, event and mode fields
  localparam int STAT_LINK = 2;
  localparam int EV_COL = 0;
  localparam int EV_CRS = 1;
  localparam int MODE_RMII = 0;
  localparam int MODE_REPEATER = 1;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Synchronised pin bundle positions
  // ************************************************************
  localparam int P_TXEN = 0;
  localparam int P_RXCLK = 1;
  localparam int P_RXBIT = 2;
  localparam int P_LVALID = 3;
  localparam int P_ANLINK = 4;
  localparam int P_LINK10 = 5;
  localparam int P_ANFDX = 6;
  localparam int P_AN100 = 7;
  localparam int P_TXD = 8;
  localparam int P_RXD = 12;
  localparam int PIN_W = 16;

  // ************************************************************
  // 4B5B code groups, first received bit in the MSB
  // ************************************************************
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_IDLE = 5'h1F;
  localparam logic [9:0] WIN_ONES = 10'h3FF;
  localparam logic [2:0] SYM_LAST_BIT = 3'h4;

  typedef enum logic [1:0] {LINK_DOWN, LINK_WAIT, LINK_READY, LINK_UP} link_state_type;
  typedef enum logic [1:0] {CS_IDLE, CS_CARRIER, CS_STREAM} cs_state_type;

endpackage

//--- rtl/carrier_if.sv
// Bit stream and carrier result between the status top and the carrier detector.
// Assumes both ends run on the same system clock.
interface carrier_if;
  logic bit_stb;
  logic bit_val;
  logic clear;
  logic crs;
  modport src (output bit_stb, output bit_val, output clear, input crs);
  modport det (input bit_stb, input bit_val, input clear, output crs);
endinterface

//--- rtl/carrier_sense.sv
// Carrier detector working on the unscrambled 5-bit code-group stream.
// Assumes one bit strobe per received code bit, already in the system clock domain.
module carrier_sense (
  input wire logic clk,
  input wire logic nrst,
  carrier_if.det cs
);

  typedef struct packed {
    logic [9:0] win;
    phy_pkg::cs_state_type st;
    logic [2:0] bit_cnt;
    logic [4:0] prev_sym;
    logic crs;
  } cs_reg_type;

  cs_reg_type r_reg;
  cs_reg_type r_next;

  // True when two zeros with at least one bit between them lie in the window
  function automatic logic split_zeros(input logic [9:0] w);
    logic hit;
    logic far;
    logic near;
    hit = 1'b0;
    far = 1'b0;
    near = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (!w[i] && far) begin
        hit = 1'b1;
      end
      far = far | near;
      near = !w[i];
    end
    return hit;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [9:0] win_n;
    logic [4:0] sym;
    win_n = {r_reg.win[8:0], cs.bit_val};
    sym = win_n[4:0];
    r_next = r_reg;
    if (cs.clear) begin
      r_next.win = phy_pkg::WIN_ONES;
      r_next.st = phy_pkg::CS_IDLE;
      r_next.bit_cnt = 3'h0;
      r_next.prev_sym = phy_pkg::SYM_IDLE;
      r_next.crs = 1'b0;
    end else if (cs.bit_stb) begin
      r_next.win = win_n;
      unique case (r_reg.st)
        phy_pkg::CS_IDLE: begin
          if (split_zeros(win_n)) begin
            r_next.st = phy_pkg::CS_CARRIER;
            r_next.crs = 1'b1;
          end
        end
        phy_pkg::CS_CARRIER: begin
          if (win_n == {phy_pkg::SYM_J, phy_pkg::SYM_K}) begin
            r_next.st = phy_pkg::CS_STREAM;
            r_next.bit_cnt = 3'h0;
            r_next.prev_sym = phy_pkg::SYM_K;
          end else if (win_n == phy_pkg::WIN_ONES) begin
            r_next.st = phy_pkg::CS_IDLE;
            r_next.crs = 1'b0;
          end
        end
        phy_pkg::CS_STREAM: begin
          r_next.bit_cnt = (r_reg.bit_cnt == phy_pkg::SYM_LAST_BIT) ? 3'h0 :
            r_reg.bit_cnt + 3'h1;
          if (r_reg.bit_cnt == phy_pkg::SYM_LAST_BIT) begin
            r_next.prev_sym = sym;
            // end on T R or two IDLE
            // lone T or IDLE keeps carrier
            if ((r_reg.prev_sym == phy_pkg::SYM_T && sym == phy_pkg::SYM_R) ||
                (r_reg.prev_sym == phy_pkg::SYM_IDLE && sym == phy_pkg::SYM_IDLE)) begin
              r_next.st = phy_pkg::CS_IDLE;
              r_next.crs = 1'b0;
              r_next.win = phy_pkg::WIN_ONES;
            end
          end
        end
        // Unused state code falls back to idle
        default: begin
          r_next.st = phy_pkg::CS_IDLE;
          r_next.crs = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '{win: 10'h3FF, st: phy_pkg::CS_IDLE, bit_cnt: 3'h0,
        prev_sym: 5'h1F, crs: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign cs.crs = r_reg.crs;

endmodule // carrier_sense

//--- rtl/phy_carrier_link_status.sv
// Status and test logic of a 10/100 transceiver: soft reset, carrier sense,
// collision, link integrity, near-end loopback and the register file.
// Assumes AXI4-Lite from software and unsynchronised pins from the line side.

module phy_carrier_link_status #(
  parameter logic [25:0] SRST_CYCLES = 26'(phy_pkg::SRST_CYCLES),
  parameter logic [15:0] LINK_WAIT_CYCLES = 16'(phy_pkg::LINK_WAIT_CYCLES)
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic TXEN,
  input wire logic [3:0] TXD,
  input wire logic RX_CODE_CLK,
  input wire logic RX_CODE_BIT,
  input wire logic [3:0] RXD_LINE,
  input wire logic LINE_VALID,
  input wire logic AN_LINK_ENABLE,
  input wire logic AN_FULL_DUPLEX,
  input wire logic AN_SPEED_100,
  input wire logic LINK10_OK,
  output logic [3:0] RXD,
  output logic CRS,
  output logic CRS_DV,
  output logic COL,
  output logic LINK_INDICATOR_OUTPUT,
  output logic TX_POWER_DOWN
);

  typedef struct packed {
    logic [15:0] pin_s1;
    logic [15:0] pin_s2;
    logic rxclk_prev;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [15:0] ctrl;
    logic [1:0] mode;
    logic [1:0] events;
    logic srst_busy;
    logic [25:0] srst_cnt;
    phy_pkg::link_state_type link_st;
    logic [15:0] link_cnt;
    logic crs;
    logic crs_dv;
    logic col;
    logic link;
    logic tx_pd;
    logic [3:0] rxd;
  } top_state_type;

  top_state_type r_reg;
  top_state_type r_next;
  carrier_if cs_bus ();

  // Merge two byte lanes of write data into an old 16-bit value
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
      input logic [15:0] new_v, input logic [1:0] strb);
    return {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // Word index of a byte address, or an out-of-range marker if misaligned
  function automatic logic [7:0] word_index(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) ? {2'h0, addr[7:2]} : 8'hFF;
  endfunction

  // ************************************************************
  // Carrier detector
  // ************************************************************
  carrier_sense u_carrier (
    .clk(CLK),
    .nrst(NRST),
    .cs(cs_bus)
  );

  // Bit strobe on each synchronised rising edge of the code clock
  assign cs_bus.bit_stb = r_reg.pin_s2[phy_pkg::P_RXCLK] & ~r_reg.rxclk_prev;
  assign cs_bus.bit_val = r_reg.pin_s2[phy_pkg::P_RXBIT];
  assign cs_bus.clear = r_reg.srst_busy;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic an_en;
    logic fdx;
    logic spd100;
    logic loop;
    logic coltest;
    logic txact;
    logic rxact;
    logic crs_any;
    logic lvalid;
    logic [7:0] widx;
    logic [7:0] ridx;
    logic [15:0] wval;
    logic ev_any_wr;
    logic [1:0] ev_w1c;
    r_next = r_reg;
    wval = 16'h0;
    ev_any_wr = 1'b0;
    ev_w1c = 2'h0;

    r_next.pin_s1 = {RXD_LINE, TXD, AN_SPEED_100, AN_FULL_DUPLEX, LINK10_OK,
      AN_LINK_ENABLE, LINE_VALID, RX_CODE_BIT, RX_CODE_CLK, TXEN};
    r_next.pin_s2 = r_reg.pin_s1;
    r_next.rxclk_prev = r_reg.pin_s2[phy_pkg::P_RXCLK];

    // negotiated results override manual speed and duplex
    an_en = r_reg.ctrl[phy_pkg::CTRL_ANEN];
    fdx = an_en ? r_reg.pin_s2[phy_pkg::P_ANFDX] : r_reg.ctrl[phy_pkg::CTRL_DUPLEX];
    spd100 = an_en ? r_reg.pin_s2[phy_pkg::P_AN100] : r_reg.ctrl[phy_pkg::CTRL_SPEED];
    loop = r_reg.ctrl[phy_pkg::CTRL_LOOP];
    coltest = r_reg.ctrl[phy_pkg::CTRL_COLTEST];
    txact = r_reg.pin_s2[phy_pkg::P_TXEN];
    rxact = cs_bus.crs;
    lvalid = r_reg.pin_s2[phy_pkg::P_LVALID];

    // carrier source depends on duplex and repeater mode
    crs_any = (fdx || r_reg.mode[phy_pkg::MODE_REPEATER]) ? rxact : (rxact | txact);
    r_next.crs = ~r_reg.mode[phy_pkg::MODE_RMII] & crs_any;
    r_next.crs_dv = r_reg.mode[phy_pkg::MODE_RMII] & crs_any;

    r_next.col = (coltest & txact) | (~loop & ~fdx & txact & rxact);

    r_next.tx_pd = loop | r_reg.srst_busy;
    r_next.rxd = loop ? r_reg.pin_s2[phy_pkg::P_TXD +: 4] : r_reg.pin_s2[phy_pkg::P_RXD +: 4];

    // Link state machine
    unique case (r_reg.link_st)
      phy_pkg::LINK_DOWN: begin
        r_next.link_cnt = 16'h0;
        if (lvalid) begin
          r_next.link_st = an_en ? phy_pkg::LINK_WAIT : phy_pkg::LINK_UP;
        end
      end
      phy_pkg::LINK_WAIT: begin
        r_next.link_cnt = r_reg.link_cnt + 16'h1;
        if (r_reg.link_cnt == LINK_WAIT_CYCLES - 16'h1) begin
          r_next.link_st = phy_pkg::LINK_READY;
        end
        // negotiation turned off, skip the wait
        if (!an_en) begin
          r_next.link_st = phy_pkg::LINK_UP;
        end
      end
      phy_pkg::LINK_READY: begin
        if (r_reg.pin_s2[phy_pkg::P_ANLINK] || !an_en) begin
          r_next.link_st = phy_pkg::LINK_UP;
        end
      end
      phy_pkg::LINK_UP: begin
        r_next.link_cnt = 16'h0;
      end
    endcase
    if (!lvalid) begin
      r_next.link_st = phy_pkg::LINK_DOWN;
    end

    // combine 100 and 10 Mbps link
    // 10 Mbps link from 10BASE-T receiver
    r_next.link = spd100 ? (r_reg.link_st == phy_pkg::LINK_UP) :
      r_reg.pin_s2[phy_pkg::P_LINK10];

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    if (AWVALID && !r_reg.aw_have) begin
      r_next.aw_have = 1'b1;
      r_next.aw_addr = AWADDR;
    end
    if (WVALID && !r_reg.w_have) begin
      r_next.w_have = 1'b1;
      r_next.w_data = WDATA[15:0];
      r_next.w_strb = WSTRB[1:0];
    end
    if (r_reg.bvalid && BREADY) begin
      r_next.bvalid = 1'b0;
    end
    widx = word_index(r_reg.aw_addr);
    if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
      r_next.aw_have = 1'b0;
      r_next.w_have = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = phy_pkg::RESP_OKAY;
      unique case (widx)
        phy_pkg::IDX_CTRL: begin
          wval = lane_merge(r_reg.ctrl, r_reg.w_data, r_reg.w_strb);
          if (!r_reg.srst_busy) begin
            // soft reset write takes no other bits
            if (wval[phy_pkg::CTRL_SRST]) begin
              r_next.srst_busy = 1'b1;
              r_next.srst_cnt = 26'h0;
            end else begin
              r_next.ctrl = wval & phy_pkg::CTRL_WMASK;
            end
          end
        end
        phy_pkg::IDX_STAT: begin
          r_next.bresp = phy_pkg::RESP_OKAY;
        end
        phy_pkg::IDX_EVENT: begin
          ev_any_wr = 1'b1;
          ev_w1c = r_reg.w_strb[0] ? r_reg.w_data[1:0] : 2'h0;
        end
        phy_pkg::IDX_MODE: begin
          if (r_reg.w_strb[0]) begin
            r_next.mode = r_reg.w_data[1:0];
          end
        end
        default: begin
          r_next.bresp = phy_pkg::RESP_SLVERR;
        end
      endcase
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    if (r_reg.rvalid && RREADY) begin
      r_next.rvalid = 1'b0;
    end
    ridx = word_index(ARADDR);
    if (ARVALID && !r_reg.rvalid) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = phy_pkg::RESP_OKAY;
      r_next.rdata = 16'h0;
      unique case (ridx)
        phy_pkg::IDX_CTRL: begin
          r_next.rdata = r_reg.ctrl;
          r_next.rdata[phy_pkg::CTRL_SRST] = r_reg.srst_busy;
        end
        phy_pkg::IDX_STAT: begin
          r_next.rdata[phy_pkg::STAT_LINK] = r_reg.link;
        end
        phy_pkg::IDX_EVENT: begin
          r_next.rdata[1:0] = r_reg.events;
        end
        phy_pkg::IDX_MODE: begin
          r_next.rdata[1:0] = r_reg.mode;
        end
        default: begin
          r_next.rresp = phy_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Sticky events; a new event wins over a clear in the same cycle
    r_next.events[phy_pkg::EV_COL] = (r_reg.events[phy_pkg::EV_COL] & ~ev_any_wr) |
      r_reg.col;
    r_next.events[phy_pkg::EV_CRS] = (r_reg.events[phy_pkg::EV_CRS] &
      ~ev_w1c[phy_pkg::EV_CRS]) | rxact;

    // soft reset reloads control defaults, clears events, link and carrier; mode bits kept
    // sequence length bounded by half a second
    if (r_reg.srst_busy) begin
      r_next.ctrl = phy_pkg::CTRL_RESET;
      r_next.events = 2'h0;
      r_next.link_st = phy_pkg::LINK_DOWN;
      r_next.link_cnt = 16'h0;
      r_next.srst_cnt = r_reg.srst_cnt + 26'h1;
      if (r_reg.srst_cnt == SRST_CYCLES - 26'h1) begin
        r_next.srst_busy = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      r_reg <= '{pin_s1: 16'h0, pin_s2: 16'h0, rxclk_prev: 1'b0, aw_have: 1'b0,
        aw_addr: 8'h0, w_have: 1'b0, w_data: 16'h0, w_strb: 2'h0, bvalid: 1'b0,
        bresp: 2'h0, rvalid: 1'b0, rdata: 16'h0, rresp: 2'h0,
        ctrl: phy_pkg::CTRL_RESET, mode: phy_pkg::MODE_RESET, events: 2'h0,
        srst_busy: 1'b0, srst_cnt: 26'h0, link_st: phy_pkg::LINK_DOWN,
        link_cnt: 16'h0, crs: 1'b0, crs_dv: 1'b0, col: 1'b0, link: 1'b0,
        tx_pd: 1'b0, rxd: 4'h0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign AWREADY = ~r_reg.aw_have;
  assign WREADY = ~r_reg.w_have;
  assign BVALID = r_reg.bvalid;
  assign BRESP = r_reg.bresp;
  assign ARREADY = ~r_reg.rvalid;
  assign RVALID = r_reg.rvalid;
  assign RRESP = r_reg.rresp;
  assign RDATA = {16'h0, r_reg.rdata};
  assign RXD = r_reg.rxd;
  assign CRS = r_reg.crs;
  assign CRS_DV = r_reg.crs_dv;
  // COL from system clock, unaligned to MII clocks
  assign COL = r_reg.col;
  assign LINK_INDICATOR_OUTPUT = r_reg.link;
  assign TX_POWER_DOWN = r_reg.tx_pd;

endmodule // phy_carrier_link_status

//--- verif/phy_carrier_link_status_assertions.sv
// Checker on the bus and line-side ports of the status block.
// Assumes binding into the top module by port name.
module phy_status_checker (
  input logic CLK,
  input logic NRST,
  input logic AWVALID,
  input logic WVALID,
  input logic BVALID,
  input logic BREADY,
  input logic [1:0] BRESP,
  input logic ARVALID,
  input logic ARREADY,
  input logic RVALID,
  input logic RREADY,
  input logic [31:0] RDATA,
  input logic TXEN,
  input logic COL,
  input logic CRS,
  input logic CRS_DV,
  input logic LINE_VALID,
  input logic LINK10_OK,
  input logic LINK_INDICATOR_OUTPUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ****
  // Bus answers
  // ****
  property p_wr_cause; $rose(BVALID) |-> $past(AWVALID, 2) || $past(WVALID, 2); endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("write answer unasked");
  property p_wr_code; BVALID |-> BRESP == phy_pkg::RESP_OKAY || BRESP == phy_pkg::RESP_SLVERR;
  endproperty
  a_wr_code: assert property (p_wr_code) else $error("bad write code");
  property p_rd_cause; $rose(RVALID) |-> $past(ARVALID); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read answer unasked");
  property p_rd_block; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  a_rd_block: assert property (p_rd_block) else $error("read answer dropped");
  property p_rd_upper; RVALID |-> RDATA[31:16] == 16'h0000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  // ****
  // Line side
  // ****
  property p_one_crs; !(CRS && CRS_DV); endproperty
  a_one_crs: assert property (p_one_crs) else $error("carrier on both pins");
  property p_col_tx; !TXEN [*5] |-> !COL; endproperty
  a_col_tx: assert property (p_col_tx) else $error("collision without transmit");
  property p_link_drop; (!LINE_VALID && !LINK10_OK) [*6] |-> !LINK_INDICATOR_OUTPUT; endproperty
  a_link_drop: assert property (p_link_drop) else $error("link kept without line");
  c_write: cover property (BVALID && BREADY);
  c_read: cover property (RVALID && RREADY);
  c_col: cover property ($rose(COL));
  c_link: cover property ($rose(LINK_INDICATOR_OUTPUT));
endmodule // phy_status_checker

bind phy_carrier_link_status phy_status_checker u_chk (.*);

//--- verif/mac_model.sv
// Controller stand-in on the transmit side of the media interface.
// Assumes the block's clock; pins change just after rising edges.
module mac_model (
  input logic clk,
  input logic col,
  output logic tx_en,
  output logic [3:0] txd,
  output logic col_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] col_sync_reg;
  initial begin
    tx_en = 1'b0;
    txd = 4'hF;
  end
  always_ff @(posedge clk) begin
    col_sync_reg <= {col_sync_reg[0], col};
  end
  assign col_seen = col_sync_reg[1];
  // Frame start and end; released data shows its inverse
  task automatic start(input logic [3:0] d);
    tx_en <= 1'b1;
    txd <= d;
    @(posedge clk);
  endtask
  task automatic stop();
    tx_en <= 1'b0;
    txd <= ~txd;
    @(posedge clk);
  endtask
endmodule // mac_model

//--- verif/tb_phy_carrier_link_status.sv
// Self-checking bench for the transceiver status block.
// Assumes the design under rtl/ and the stand-in in mac_model.sv.
module tb_phy_carrier_link_status;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] A_CTL = 8'(phy_pkg::IDX_CTRL * 4);
  localparam logic [7:0] A_ST = 8'(phy_pkg::IDX_STAT * 4);
  localparam logic [7:0] A_EV = 8'(phy_pkg::IDX_EVENT * 4);
  localparam logic [7:0] A_MD = 8'(phy_pkg::IDX_MODE * 4);
  localparam logic [1:0] OK = phy_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = phy_pkg::RESP_SLVERR;
  localparam logic [4:0] D = 5'h1E;
  localparam logic [4:0] T = phy_pkg::SYM_T;
  localparam logic [4:0] I = phy_pkg::SYM_IDLE;
  logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, txen, rxclk, rxbit, lvalid, anen, anfdx, an100, l10;
  logic crs, crs_dv, col, link, txpd, col_seen;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] txd, rxd_line, rxd, wstrb;
  logic [1:0] bresp, rresp;
  logic [4:0] obs;
  int failures, n_tests;
  assign obs = {txpd, crs_dv, crs, col, link};
  phy_carrier_link_status #(.SRST_CYCLES(26'h14), .LINK_WAIT_CYCLES(16'hA)) u_dut (
    .CLK(clk), .NRST(nrst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .TXEN(txen), .TXD(txd), .RX_CODE_CLK(rxclk), .RX_CODE_BIT(rxbit),
    .RXD_LINE(rxd_line), .LINE_VALID(lvalid), .AN_LINK_ENABLE(anen),
    .AN_FULL_DUPLEX(anfdx), .AN_SPEED_100(an100), .LINK10_OK(l10), .RXD(rxd),
    .CRS(crs), .CRS_DV(crs_dv), .COL(col), .LINK_INDICATOR_OUTPUT(link),
    .TX_POWER_DOWN(txpd));
  mac_model u_mac (.clk(clk), .col(col), .tx_en(txen), .txd(txd), .col_seen(col_seen));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****
  // Shared tasks
  // ****
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    int k;
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(k < 40 && bresp === er, "write answer");
    if (k == 40) stop_test();
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] ex, input logic [1:0] er);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk(k < 40 && rdata === {16'h0000, ex} && rresp === er, "read value");
    if (k == 40) stop_test();
    @(posedge clk);
  endtask
  task automatic wt(input int i, input logic v, input int n);
    for (int k = 0; k < n && obs[i] !== v; k++) @(posedge clk);
    chk(obs[i] === v, "pin level");
    if (obs[i] !== v) stop_test();
  endtask
  // Code bits, first bit first, on a free-phase 125 ns code clock
  task automatic sym(input logic [9:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      #3 rxbit = b[i];
      #59.5 rxclk = 1'b1;
      #62.5 rxclk = 1'b0;
    end
    @(posedge clk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    rd(A_CTL, phy_pkg::CTRL_RESET, OK);
    wr(A_ST, 16'hFFFF, OK);
    rd(A_ST, 16'h0000, OK);
    wr(8'h44, 16'h0001, ERR);
    rd(8'h0C, 16'h0000, ERR);
    wr(A_CTL, 16'h7FFF, OK);
    rd(A_CTL, phy_pkg::CTRL_WMASK, OK);
    wstrb <= 4'h2;
    wr(A_CTL, 16'h0000, OK);
    wstrb <= 4'hF;
    rd(A_CTL, 16'h0080, OK);
    $display("registers done");
  endtask
  task automatic t_loop();
    wr(A_CTL, 16'h4080, OK);
    u_mac.start(4'hA);
    wt(1, 1'b1, 512);
    chk(rxd === 4'hA && txpd === 1'b1 && crs === 1'b1, "loop");
    repeat (2) @(posedge clk);
    chk(col_seen === 1'b1, "mac sync");
    u_mac.stop();
    wt(1, 1'b0, 4);
    wr(A_CTL, 16'h4100, OK);
    u_mac.start(4'h5);
    repeat (6) @(posedge clk);
    chk(col === 1'b0 && crs === 1'b0 && rxd === 4'h5 && txpd === 1'b1, "fdx loop");
    u_mac.stop();
    $display("loopback done");
  endtask
  task automatic t_carrier();
    wr(A_CTL, 16'h0000, OK);
    sym(10'h3FF, 10);
    chk(crs === 1'b0 && rxd === 4'h6, "quiet");
    sym(10'h002, 3);
    wt(2, 1'b1, 6);
    sym(10'h3FF, 10);
    wt(2, 1'b0, 6);
    sym({phy_pkg::SYM_J, phy_pkg::SYM_K}, 10);
    wt(2, 1'b1, 6);
    u_mac.start(4'h3);
    wt(1, 1'b1, 6);
    u_mac.stop();
    wt(1, 1'b0, 6);
    sym({T, D}, 10);
    chk(crs === 1'b1, "t hold");
    sym({I, D}, 10);
    chk(crs === 1'b1, "idle hold");
    sym({I, I}, 10);
    wt(2, 1'b0, 6);
    wr(A_MD, 16'h0001, OK);
    sym({phy_pkg::SYM_J, phy_pkg::SYM_K}, 10);
    wt(3, 1'b1, 6);
    chk(crs === 1'b0, "mii quiet");
    sym({T, phy_pkg::SYM_R}, 10);
    wt(3, 1'b0, 6);
    wr(A_MD, 16'h0000, OK);
    rd(A_EV, 16'h0003, OK);
    wr(A_EV, 16'h0000, OK);
    rd(A_EV, 16'h0002, OK);
    wr(A_EV, 16'h0002, OK);
    rd(A_EV, 16'h0000, OK);
    $display("carrier done");
  endtask
  task automatic t_srst();
    wr(A_MD, 16'h0002, OK);
    wr(A_CTL, 16'h4000, OK);
    wr(A_CTL, 16'hC080, OK);
    rd(A_CTL, 16'hB000, OK);
    chk(txpd === 1'b1, "held");
    wt(4, 1'b0, 40);
    rd(A_CTL, phy_pkg::CTRL_RESET, OK);
    rd(A_MD, 16'h0002, OK);
    $display("soft reset done");
  endtask
  task automatic t_link();
    wr(A_CTL, 16'h1000, OK);
    lvalid <= 1'b1;
    repeat (10) @(posedge clk);
    chk(link === 1'b0, "early link");
    wt(0, 1'b1, 20);
    rd(A_ST, 16'h0004, OK);
    lvalid <= 1'b0;
    wt(0, 1'b0, 5);
    anen <= 1'b0;
    lvalid <= 1'b1;
    repeat (20) @(posedge clk);
    chk(link === 1'b0, "no enable");
    wr(A_CTL, 16'h2000, OK);
    wt(0, 1'b1, 5);
    wr(A_CTL, 16'h0000, OK);
    l10 <= 1'b1;
    wt(0, 1'b1, 6);
    l10 <= 1'b0;
    wt(0, 1'b0, 6);
    $display("link done");
  endtask
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, rxclk, rxbit} = 8'h00;
    {lvalid, anfdx, l10, anen, an100} = 5'h03;
    {awaddr, araddr, wdata} = 48'h0;
    rxd_line = 4'h6;
    wstrb = 4'hF;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_loop();
    t_carrier();
    t_srst();
    t_link();
    stop_test();
  end
endmodule // tb_phy_carrier_link_status
